/* rtl/sbt_pkg.sv */
// constants and types shared by the buzzer tone generator files
// assumes a 100 MHz core clock and a 32.768 kHz nominal oscillator rate
package sbt_pkg;
	// core clock and nominal low-speed oscillator rate
	localparam int unsigned SBT_CLK_HZ = 100_000_000;
	localparam int unsigned SBT_OSC_HZ = 32768;
	// register byte offsets
	localparam logic [11:0] SBT_ADDR_CLK = 12'h000;
	localparam logic [11:0] SBT_ADDR_CTL = 12'h004;
	localparam logic [11:0] SBT_ADDR_FREQ = 12'h008;
	localparam logic [11:0] SBT_ADDR_DUTY = 12'h00c;
	// field positions
	localparam int SBT_CLKE_BIT = 0;
	localparam int SBT_RUN_BIT = 0;
	localparam int SBT_MODE_LSB = 2;
	localparam int SBT_TIME_LSB = 4;
	// reset values
	localparam logic SBT_CLKE_RST = 1'b0;
	localparam logic [2:0] SBT_FREQ_RST = 3'h0;
	localparam logic [2:0] SBT_DUTY_RST = 3'h0;
	localparam logic [1:0] SBT_TIME_RST = 2'h0;
	// volume levels: code 0 loudest, code 7 softest
	localparam logic [2:0] SBT_LVL_MAX = 3'h0;
	localparam logic [2:0] SBT_LVL_MIN = 3'h7;
	// tone period in half oscillator ticks: base plus step per code
	localparam logic [5:0] SBT_PER_BASE = 6'h10;
	localparam logic [5:0] SBT_PER_STEP = 6'h04;
	// high time numerators for the short and the long period groups
	localparam logic [5:0] SBT_HI_SHORT = 6'h08;
	localparam logic [5:0] SBT_HI_LONG = 6'h0c;
	// shortest one-shot or envelope interval, in ms, and as oscillator ticks
	localparam real SBT_T0_MS = 15.625;
	localparam int SBT_T0_TICKS = $rtoi(SBT_T0_MS * SBT_OSC_HZ / 1000.0);
	typedef enum logic [1:0] {SBT_NORMAL, SBT_ONESHOT, SBT_ENVELOPE, SBT_RESERVED} sbt_mode_t;
	typedef enum logic {SBT_IDLE, SBT_PLAY} sbt_state_t;
endpackage

/* rtl/sbt_osc_tick.sv */
// enable pulse generator standing in for the gated oscillator clock
// assumes one core clock; tick rate is an exact average of TICK_HZ
`timescale 1ns/1ps
module sbt_osc_tick #(
	parameter int unsigned CLK_HZ = 100_000_000,
	parameter int unsigned TICK_HZ = 65536
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic enable,
	output logic tick
);
	logic [31:0] acc;
	logic [32:0] sum;

	// phase accumulator, frozen while the clock supply is off
	assign sum = {1'b0, acc} + 33'(TICK_HZ);
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			acc <= 32'h0;
			tick <= 1'b0;
		end else if (enable) begin
			if (sum >= 33'(CLK_HZ)) begin
				acc <= 32'(sum - 33'(CLK_HZ));
				tick <= 1'b1;
			end else begin
				acc <= sum[31:0];
				tick <= 1'b0;
			end
		end else begin
			tick <= 1'b0;
		end
	end
endmodule

/* rtl/sbt_tone_wave.sv */
// square wave with programmable period and high time
// assumes step pulses at twice the oscillator rate
`timescale 1ns/1ps
module sbt_tone_wave (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic step,
	input wire logic run,
	input wire logic [2:0] freqSel,
	input wire logic [2:0] dutySel,
	output logic wave
);
	import sbt_pkg::*;
	logic pre;
	logic [5:0] cnt;
	logic [5:0] period;
	logic [5:0] highCnt;

	// period 16/20/24/28 half ticks, doubled by the prescaler for codes 4-7
	assign period = SBT_PER_BASE + 6'(SBT_PER_STEP * freqSel[1:0]);
	assign highCnt = (freqSel[1] ? SBT_HI_LONG : SBT_HI_SHORT) - {3'h0, dutySel};
	assign wave = run && (cnt < highCnt);

	// phase counter, held at zero while no tone plays; wraps at once if the period shrinks mid-tone
	always_ff @(posedge core_clk) begin
		if (sys_rst || !run) begin
			pre <= 1'b0;
			cnt <= 6'h0;
		end else if (step) begin
			pre <= freqSel[2] ? ~pre : 1'b0;
			if (!freqSel[2] || pre) begin
				cnt <= (cnt >= period - 6'h1) ? 6'h0 : cnt + 6'h1;
			end
		end
	end
endmodule

/* rtl/sbt_tone_gen.sv */
// buzzer tone generator: APB registers, mode control, complementary outputs
// assumes a synchronous APB master on core_clk and pins muxed outside
//
// Summary of operation
// - all tone and timing derive from a 32.768 kHz oscillator tick
// - clock enable resets to 0 and blocks the oscillator tick
// - frequency codes 0-7 give 4096 down to 1170.3 Hz, reset 0
// - volume sets duty (8-n) or (12-n) over 16/20/24/28 steps
// - volume resets to code 0 loudest, code 7 softest
// - envelope mode ignores the software volume field
// - mode field: 0 normal, 1 one-shot, 2 envelope, 3 reserved
// - normal mode tone follows the run bit, never stops alone
// - one-shot trigger plays tone, stops itself after selected time
// - envelope trigger starts loudest, steps down, ends at softest
// - two outputs: tone and its exact complement
// - frequencies and times scale with the oscillator rate
// - normal mode: write 1 starts, write 0 stops tone
// - time field picks 15.63, 31.25, 62.5 or 125 ms, reset 0
// - run bit reads 1 while playing, clears itself at a one-shot or envelope end, write 0 stops
// - envelope duty steps down one level per selected interval
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module sbt_tone_gen #(
	parameter int unsigned OSC_HZ = sbt_pkg::SBT_OSC_HZ
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic toneOut,
	output logic toneOutN
);
	import sbt_pkg::*;

	logic clkEn;
	logic [2:0] freqSel;
	logic [2:0] volSel;
	sbt_mode_t modeSel;
	logic [1:0] timeSel;
	sbt_state_t state;
	logic [2:0] level;
	logic [12:0] timeCnt;
	logic [12:0] interval;
	logic halfTick;
	logic oscPhase;
	logic oscTick;
	logic timeDone;
	logic endNow;
	logic wave;
	logic [2:0] dutyEff;
	logic access;
	logic wrEn;
	logic wrCtl;
	logic trigger;
	logic playing;
	logic mapped;
	logic [31:0] next_prdata;

	// apb decode; a write lands on the completing edge only
	assign access = psel && penable && pready;
	assign wrEn = access && pwrite;
	assign wrCtl = wrEn && (paddr == SBT_ADDR_CTL);
	assign trigger = wrCtl && pwdata[SBT_RUN_BIT];
	assign playing = (state == SBT_PLAY);
	assign mapped = (paddr == SBT_ADDR_CLK) || (paddr == SBT_ADDR_CTL) ||
		(paddr == SBT_ADDR_FREQ) || (paddr == SBT_ADDR_DUTY);

	// double-rate half ticks let the 4096 Hz tone reach sixteenth duty steps
	sbt_osc_tick #(
		.CLK_HZ(SBT_CLK_HZ),
		.TICK_HZ(2 * OSC_HZ)
	) u_tick (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.enable(clkEn),
		.tick(halfTick)
	);

	// every second half tick is one oscillator period
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			oscPhase <= 1'b0;
		end else if (halfTick) begin
			oscPhase <= ~oscPhase;
		end
	end
	assign oscTick = halfTick && oscPhase;

	// apb wait state: one cycle, then data and error from flops
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
			prdata <= next_prdata;
			pslverr <= psel && penable && !pready && !mapped;
		end
	end

	// read mux; unmapped reads as zero
	always_comb begin
		next_prdata = 32'h0;
		if (psel && !pwrite) begin
			case (paddr)
				SBT_ADDR_CLK: next_prdata[SBT_CLKE_BIT] = clkEn;
				SBT_ADDR_CTL: begin
					next_prdata[SBT_RUN_BIT] = playing;
					next_prdata[SBT_MODE_LSB +: 2] = modeSel;
					next_prdata[SBT_TIME_LSB +: 2] = timeSel;
				end
				SBT_ADDR_FREQ: next_prdata[2:0] = freqSel;
				SBT_ADDR_DUTY: next_prdata[2:0] = volSel;
				default: next_prdata = 32'h0;
			endcase
		end
	end

	// clock supply enable
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			clkEn <= SBT_CLKE_RST;
		end else if (wrEn && paddr == SBT_ADDR_CLK) begin
			clkEn <= pwdata[SBT_CLKE_BIT];
		end
	end

	// mode and time fields
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			modeSel <= SBT_NORMAL;
			timeSel <= SBT_TIME_RST;
		end else if (wrCtl) begin
			modeSel <= sbt_mode_t'(pwdata[SBT_MODE_LSB +: 2]);
			timeSel <= pwdata[SBT_TIME_LSB +: 2];
		end
	end

	// frequency and volume fields
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			freqSel <= SBT_FREQ_RST;
			volSel <= SBT_DUTY_RST;
		end else if (wrEn) begin
			if (paddr == SBT_ADDR_FREQ) begin
				freqSel <= pwdata[2:0];
			end
			if (paddr == SBT_ADDR_DUTY) begin
				volSel <= pwdata[2:0];
			end
		end
	end

	// interval timer in oscillator ticks: 512 << code
	assign interval = 13'(SBT_T0_TICKS) << timeSel;
	assign timeDone = playing && oscTick && (timeCnt == interval - 13'h1);
	always_ff @(posedge core_clk) begin
		if (sys_rst || trigger || !playing) begin
			timeCnt <= 13'h0;
		end else if (oscTick) begin
			timeCnt <= timeDone ? 13'h0 : timeCnt + 13'h1;
		end
	end

	// self-stop for one-shot expiry and envelope reaching the softest step
	always_comb begin
		case (modeSel)
			SBT_ONESHOT: endNow = timeDone;
			SBT_ENVELOPE: endNow = timeDone && (level == SBT_LVL_MIN - 3'h1);
			default: endNow = 1'b0;
		endcase
	end

	// play state: a software write wins over a same-cycle self-stop
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state <= SBT_IDLE;
		end else begin
			case (state)
				SBT_IDLE: begin
					if (trigger) begin
						state <= SBT_PLAY;
					end
				end
				SBT_PLAY: begin
					if (wrCtl && !pwdata[SBT_RUN_BIT]) begin
						state <= SBT_IDLE;
					end else if (!trigger && endNow) begin
						state <= SBT_IDLE;
					end
				end
				default: state <= SBT_IDLE;
			endcase
		end
	end

	// envelope level, restarted at the loudest step on every trigger
	always_ff @(posedge core_clk) begin
		if (sys_rst || trigger) begin
			level <= SBT_LVL_MAX;
		end else if (modeSel == SBT_ENVELOPE && timeDone && level != SBT_LVL_MIN) begin
			level <= level + 3'h1;
		end
	end
	assign dutyEff = (modeSel == SBT_ENVELOPE) ? level : volSel;

	sbt_tone_wave u_wave (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.step(halfTick),
		.run(playing),
		.freqSel(freqSel),
		.dutySel(dutyEff),
		.wave(wave)
	);

	// complementary pin drivers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			toneOut <= 1'b0;
			toneOutN <= 1'b1;
		end else begin
			toneOut <= wave;
			toneOutN <= ~wave;
		end
	end

	// checks
	sequence s_trig;
		trigger;
	endsequence
	sequence s_stop_write;
		wrCtl && !pwdata[SBT_RUN_BIT];
	endsequence
	sequence s_env_last;
		modeSel == SBT_ENVELOPE && timeDone && level == SBT_LVL_MIN - 3'h1 && !trigger;
	endsequence

	property p_clk_reset;
		@(posedge core_clk) sys_rst |=> !clkEn;
	endproperty
	a_clk_reset: assert property (p_clk_reset) else $error("clock enable not cleared by reset");

	property p_clk_gate;
		@(posedge core_clk) disable iff (sys_rst) !clkEn |=> !halfTick;
	endproperty
	a_clk_gate: assert property (p_clk_gate) else $error("tick while clock disabled");

	property p_complement;
		@(posedge core_clk) disable iff (sys_rst) toneOut != toneOutN;
	endproperty
	a_complement: assert property (p_complement) else $error("outputs not complementary");

	property p_stop_write;
		@(posedge core_clk) disable iff (sys_rst) s_stop_write |=> !playing ##1 !toneOut;
	endproperty
	a_stop_write: assert property (p_stop_write) else $error("write 0 did not stop tone");

	property p_trig_start;
		@(posedge core_clk) disable iff (sys_rst) s_trig |=> playing && level == SBT_LVL_MAX && timeCnt == 13'h0;
	endproperty
	a_trig_start: assert property (p_trig_start) else $error("trigger did not restart");

	property p_oneshot_end;
		@(posedge core_clk) disable iff (sys_rst)
			modeSel == SBT_ONESHOT && timeDone && !wrCtl |=> !playing;
	endproperty
	a_oneshot_end: assert property (p_oneshot_end) else $error("one-shot did not end");

	property p_normal_hold;
		@(posedge core_clk) disable iff (sys_rst)
			modeSel == SBT_NORMAL && playing && !wrCtl |=> playing;
	endproperty
	a_normal_hold: assert property (p_normal_hold) else $error("normal mode stopped alone");

	property p_env_step;
		@(posedge core_clk) disable iff (sys_rst)
			modeSel == SBT_ENVELOPE && timeDone && !trigger && level < SBT_LVL_MIN |=> level == $past(level) + 3'h1;
	endproperty
	a_env_step: assert property (p_env_step) else $error("envelope level did not step");

	property p_env_duty;
		@(posedge core_clk) disable iff (sys_rst) modeSel == SBT_ENVELOPE |-> dutyEff == level;
	endproperty
	a_env_duty: assert property (p_env_duty) else $error("envelope used volume field");

	// envelope output ends on the step into the softest level
	property p_env_end;
		@(posedge core_clk) disable iff (sys_rst) s_env_last |=> !playing;
	endproperty
	a_env_end: assert property (p_env_end) else $error("envelope did not end at softest level");

	// no tone reaches the pins once playing has stopped
	property p_idle_quiet;
		@(posedge core_clk) disable iff (sys_rst) !playing |=> !toneOut;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("tone while stopped");

	// level only moves at an interval end or a trigger
	property p_level_hold;
		@(posedge core_clk) disable iff (sys_rst)
			modeSel == SBT_ENVELOPE && !timeDone && !trigger |=> $stable(level);
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("envelope level moved between steps");
endmodule

/* testbench/sbt_buzzer_model.sv */
// piezo buzzer model: times the complementary drive pair
// assumes the tone pins change only on core_clk edges
`timescale 1ns/1ps
module sbt_buzzer_model (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic toneOut,
	input wire logic toneOutN,
	output int highLen,
	output int periodLen,
	output int rises,
	output logic pairBad
);
	int cnt = 0;
	logic last = 1'h0;
	initial begin
		rises = 0;
		pairBad = 1'h0;
	end
	// high time and period in core cycles, pair watch
	always @(posedge core_clk) begin
		cnt <= cnt + 1;
		last <= toneOut;
		if (toneOut && !last) begin
			periodLen <= cnt;
			cnt <= 1;
			rises <= rises + 1;
		end
		if (!toneOut && last)
			highLen <= cnt;
		if (!sys_rst && toneOut === toneOutN)
			pairBad <= 1'h1;
	end
endmodule

/* testbench/sbt_tone_gen_tb_top.sv */
// self-checking bench for the buzzer tone generator
// assumes design and piezo model on one 100 MHz clock
`timescale 1ns/1ps
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin fails++; $display("wrong value %0t %s", $time, m); end end
module sbt_tone_gen_tb_top;
	import sbt_pkg::*;
	localparam int unsigned OSC = 25_000_000;
	localparam int IVL = 2048; // shortest interval, core cycles
	logic core_clk = 1'h0;
	logic sys_rst = 1'h1;
	logic [11:0] paddr = 12'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, toneOut, toneOutN, pairBad, err;
	int highLen, periodLen, rises;
	int fails = 0;
	int num_checks = 0;
	int cycles = 0;
	logic pinSel = 1'h0; // port function select outside the block
	sbt_tone_gen #(.OSC_HZ(OSC)) dut (.core_clk(core_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .toneOut(toneOut), .toneOutN(toneOutN));
	// the buzzer only sees the tone once the pins carry the buzzer function
	sbt_buzzer_model buzz (.core_clk(core_clk), .sys_rst(sys_rst), .toneOut(pinSel ? toneOut : 1'h0),
		.toneOutN(pinSel ? toneOutN : 1'h1),
		.highLen(highLen), .periodLen(periodLen), .rises(rises), .pairBad(pairBad));
	always #5 core_clk = ~core_clk;
	// hang guard
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			fails++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// one apb transfer, answer kept in rd and err
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge core_clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'h1;
		@(posedge core_clk);
		penable <= 1'h1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	function automatic logic [31:0] ctl(input logic r, input logic [1:0] m, input logic [1:0] t);
		return 32'(r) | (32'(m) << SBT_MODE_LSB) | (32'(t) << SBT_TIME_LSB);
	endfunction
	task automatic test_reset();
		apb(SBT_ADDR_CLK, 0, 0);
		`CHK(rd, 32'h0, "clock enable")
		apb(SBT_ADDR_CTL, 0, 0);
		`CHK(rd, 32'h0, "control")
		apb(SBT_ADDR_FREQ, 0, 0);
		`CHK(rd, 32'h0, "freq")
		apb(SBT_ADDR_DUTY, 0, 0);
		`CHK(rd, 32'h0, "volume")
		apb(12'h010, 0, 0);
		`CHK({err, rd}, 33'h100000000, "unmapped")
		`CHK({toneOut, toneOutN}, 2'h1, "idle pins")
		$display("reset test done");
	endtask
	task automatic test_gate();
		int r0;
		pinSel <= 1'h1;
		apb(SBT_ADDR_CTL, 1, ctl(1, 0, 0));
		idle(10);
		r0 = rises;
		idle(200);
		`CHK(rises, r0, "tone while gated")
		apb(SBT_ADDR_CLK, 1, 32'h1);
		idle(200);
		`CHK(rises > r0 + 3, 1'h1, "no tone")
		apb(SBT_ADDR_CTL, 1, 0);
		$display("gate test done");
	endtask
	task automatic test_tone();
		int per, hi, m;
		for (int f = 0; f < 8; f++) begin
			for (int v = 0; v < 8; v += 7) begin
				m = f > 3 ? 2 : 1;
				per = (4 + (f & 3)) * 8 * m;
				hi = (((f & 2) != 0 ? 12 : 8) - v) * 2 * m;
				apb(SBT_ADDR_FREQ, 1, 32'(f));
				apb(SBT_ADDR_DUTY, 1, 32'(v));
				apb(SBT_ADDR_CTL, 1, ctl(1, 0, 0));
				idle(4 * per);
				`CHK(periodLen, per, "period")
				`CHK(highLen, hi, "high time")
			end
		end
		idle(3 * IVL);
		apb(SBT_ADDR_CTL, 0, 0);
		`CHK(rd[0], 1'h1, "normal stopped")
		apb(SBT_ADDR_CTL, 1, 0);
		apb(SBT_ADDR_CTL, 0, 0);
		`CHK({rd[0], toneOut}, 2'h0, "stop")
		apb(SBT_ADDR_FREQ, 1, 0);
		apb(SBT_ADDR_DUTY, 1, 0);
		$display("tone test done");
	endtask
	task automatic test_oneshot();
		for (int t = 0; t < 4; t++) begin
			apb(SBT_ADDR_CTL, 1, ctl(1, 1, t[1:0]));
			idle((IVL << t) - 24);
			apb(SBT_ADDR_CTL, 0, 0);
			`CHK(rd[0], 1'h1, "early end")
			idle(30);
			apb(SBT_ADDR_CTL, 0, 0);
			`CHK({rd[0], toneOut}, 2'h0, "late end")
		end
		apb(SBT_ADDR_CTL, 1, ctl(1, 1, 0));
		idle(IVL / 2);
		apb(SBT_ADDR_CTL, 1, ctl(1, 1, 0));
		idle(IVL - 24);
		apb(SBT_ADDR_CTL, 0, 0);
		`CHK(rd[0], 1'h1, "retrigger")
		apb(SBT_ADDR_CTL, 1, ctl(0, 1, 0));
		apb(SBT_ADDR_CTL, 0, 0);
		`CHK({rd[0], toneOut}, 2'h0, "write stop")
		apb(SBT_ADDR_CTL, 1, ctl(1, 3, 0));
		idle(IVL + 200);
		apb(SBT_ADDR_CTL, 0, 0);
		`CHK(rd[0], 1'h1, "reserved mode")
		apb(SBT_ADDR_CTL, 1, 0);
		$display("one-shot test done");
	endtask
	task automatic test_envelope();
		apb(SBT_ADDR_DUTY, 1, 32'h7);
		apb(SBT_ADDR_CTL, 1, ctl(1, 2, 0));
		for (int k = 0; k < 7; k++) begin
			idle(k == 0 ? IVL / 2 : IVL);
			`CHK(highLen, (8 - k) * 2, "level")
		end
		idle(IVL / 2 + 30);
		apb(SBT_ADDR_CTL, 0, 0);
		`CHK({rd[0], toneOut}, 2'h0, "no end")
		apb(SBT_ADDR_CTL, 1, ctl(1, 2, 0));
		idle(2 * IVL + IVL / 2);
		`CHK(highLen, 12, "level two")
		apb(SBT_ADDR_CTL, 1, ctl(1, 2, 0));
		idle(IVL / 2);
		`CHK(highLen, 16, "restart level")
		apb(SBT_ADDR_CTL, 1, 0);
		$display("envelope test done");
	endtask
	// reset in mid-run with every field set away from its reset value
	task automatic test_midreset();
		apb(SBT_ADDR_FREQ, 1, 32'h5);
		apb(SBT_ADDR_DUTY, 1, 32'h3);
		apb(SBT_ADDR_CTL, 1, ctl(1, 1, 2'h2));
		idle(20);
		sys_rst <= 1'h1;
		idle(4);
		sys_rst <= 1'h0;
		test_reset();
	endtask
	// main sequence
	initial begin
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'h0;
		test_reset();
		test_gate();
		test_tone();
		test_oneshot();
		test_envelope();
		test_midreset();
		`CHK(pairBad, 1'h0, "pair")
		complete_run();
	end
endmodule
